/* File: design/sslc_cfg.svh */
// constants for the sync source and link control block
// assumes mclk runs at the rate given by SSLC_MCLK_PERIOD_NS
`ifndef SSLC_CFG_SVH
`define SSLC_CFG_SVH

`define SSLC_MCLK_PERIOD_NS  50
`define SSLC_FLASH_HALF_NS   250000000
`define SSLC_RATE_GATE_NS    100000000
`define SSLC_RATE_W          16
`define SSLC_DIV_W           12
`define SSLC_PRE_W           8
`define SSLC_TC_W            32
`define SSLC_NUM_PAIRS       4
`define SSLC_PIN_W           9
`define SSLC_PIN_WORD        8
`define SSLC_PIN_VIDEO       7
`define SSLC_PIN_DIG_LSB     3
`define SSLC_PIN_REF         2
`define SSLC_PIN_LINK_IN     1
`define SSLC_PIN_LINK_OUT    0
`define SSLC_PREROLL_RESET   8'h00

`endif

/* File: design/sslc_pkg.sv */
// types shared by the sync source and link control block
// assumes nothing beyond a SystemVerilog compiler
package sslc_pkg;

  typedef enum logic [2:0] {
    SYNC_INTERNAL = 3'h0,
    SYNC_WORD     = 3'h1,
    SYNC_VIDEO    = 3'h3,
    SYNC_DIG12    = 3'h2,
    SYNC_DIG34    = 3'h6,
    SYNC_DIG56    = 3'h7,
    SYNC_DIG78    = 3'h5
  } sslc_sync_e;

  typedef enum logic [1:0] {
    ROLE_NONE   = 2'h0,
    ROLE_MASTER = 2'h1,
    ROLE_SLAVE  = 2'h3
  } sslc_role_e;

  typedef enum logic [1:0] {
    CMD_NONE  = 2'h0,
    CMD_REC   = 2'h1,
    CMD_STOP  = 2'h3,
    CMD_SPLIT = 2'h2
  } sslc_cmd_e;

  typedef enum logic {
    REC_IDLE = 1'b0,
    REC_RUN  = 1'b1
  } sslc_rec_e;

endpackage

/* File: design/sslc_rate_meter.sv */
// incoming sample rate meter: counts reference edges over a fixed gate
// assumes edgePulse is a one-cycle pulse already on clk
`include "sslc_cfg.svh"
module sslc_rate_meter #(
  parameter int unsigned GATE_CYCLES = 2000000,
  parameter int unsigned RATE_W      = `SSLC_RATE_W
) (
  input  wire logic              clk,
  input  wire logic              rstN,
  input  wire logic              ce,
  input  wire logic              enable,
  input  wire logic              edgePulse,
  output logic [RATE_W-1:0]      rate,
  output logic                   rateValid
);
  logic [31:0]       gateCnt_q;
  logic [RATE_W-1:0] edgeCnt_q;
  logic              gateEnd;

  assign gateEnd = (gateCnt_q >= GATE_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!rstN || (ce && !enable)) begin
      gateCnt_q <= 32'h0;
      edgeCnt_q <= '0;
    end else if (ce) begin
      gateCnt_q <= gateEnd ? 32'h0 : gateCnt_q + 32'h1;
      if (gateEnd) begin
        edgeCnt_q <= '0;
      end else if (edgePulse && (edgeCnt_q != '1)) begin
        edgeCnt_q <= edgeCnt_q + RATE_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstN) begin
      rate      <= '0;
      rateValid <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        rateValid <= 1'b0;
      end else if (gateEnd) begin
        rate      <= edgeCnt_q;
        rateValid <= 1'b1;
      end
    end
  end

  a_rate_drop: assert property (@(posedge clk) disable iff (!rstN)
    (ce && !enable) |=> !rateValid)
    else $error("rate still shown while not locked");
endmodule

/* File: design/sslc_top.sv */
// sync source selection, lock reporting and multi-unit link control
// assumes pins arrive asynchronously; link pins are timed by linkClk
`include "sslc_cfg.svh"
module sslc_top
  import sslc_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = `SSLC_FLASH_HALF_NS / `SSLC_MCLK_PERIOD_NS,
  parameter int unsigned GATE_CYCLES  = `SSLC_RATE_GATE_NS / `SSLC_MCLK_PERIOD_NS
) (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       ce,
  input  wire logic [2:0]                 syncSel,
  input  wire logic                       wordClkValid,
  input  wire logic                       videoValid,
  input  wire logic [`SSLC_NUM_PAIRS-1:0] digValid,
  input  wire logic                       refClkIn,
  input  wire logic [`SSLC_DIV_W-1:0]     intRateHalfDiv,
  input  wire logic                       hostConnMode,
  input  wire logic                       linkInConnected,
  input  wire logic                       linkOutConnected,
  input  wire logic                       recPress,
  input  wire logic                       stopPress,
  input  wire logic                       fileLimit,
  input  wire logic                       markerNewFile,
  input  wire logic [`SSLC_PRE_W-1:0]     prerollLen,
  input  wire logic [`SSLC_TC_W-1:0]      timeCodeIn,
  input  wire logic                       linkClk,
  input  wire logic                       linkInStrobe,
  input  wire logic [1:0]                 linkInCmd,
  input  wire logic [`SSLC_PRE_W-1:0]     linkInPreroll,
  input  wire logic [`SSLC_TC_W-1:0]      linkInTc,
  output logic                            digLock,
  output logic                            wordLock,
  output logic                            videoLock,
  output logic [`SSLC_NUM_PAIRS-1:0]      activityFlash,
  output logic [`SSLC_NUM_PAIRS-1:0]      inputRateConvEnable,
  output logic                            clockSrcInternal,
  output logic                            lockLost,
  output logic [`SSLC_RATE_W-1:0]         measuredRate,
  output logic                            rateValid,
  output logic                            wordClkOut,
  output logic [1:0]                      linkRole,
  output logic                            recordActive,
  output logic                            newFilePulse,
  output logic [`SSLC_PRE_W-1:0]          prerollActive,
  output logic [`SSLC_TC_W-1:0]           rxTimeCode,
  output logic                            linkOutStrobe,
  output logic [1:0]                      linkOutCmd,
  output logic [`SSLC_PRE_W-1:0]          linkOutPreroll,
  output logic [`SSLC_TC_W-1:0]           linkOutTc
);
  // returns {is digital pair, pair index}
  function automatic logic [2:0] digPair(input logic [2:0] sel);
    case (sel)
      SYNC_DIG12: digPair = 3'h4;
      SYNC_DIG34: digPair = 3'h5;
      SYNC_DIG56: digPair = 3'h6;
      SYNC_DIG78: digPair = 3'h7;
      default:    digPair = 3'h0;
    endcase
  endfunction

  logic [`SSLC_PIN_W-1:0] pinS1_q;
  logic [`SSLC_PIN_W-1:0] pinS2_q;
  logic                   refPrev_q;
  logic [2:0]             selDig;
  logic                   extValid;
  logic                   extValid_q;
  logic [31:0]            blinkCnt_q;
  logic                   blink_q;
  logic [`SSLC_DIV_W-1:0] divCnt_q;
  logic                   genTick_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pinS1_q   <= '0;
      pinS2_q   <= '0;
      refPrev_q <= 1'b0;
    end else if (ce) begin
      pinS1_q   <= {wordClkValid, videoValid, digValid, refClkIn,
                    linkInConnected, linkOutConnected};
      pinS2_q   <= pinS1_q;
      refPrev_q <= pinS2_q[`SSLC_PIN_REF];
    end
  end

  // selections outside the seven choices fall back to the internal clock but keep the rate converters off
  always_comb begin
    selDig = digPair(syncSel);
    case (syncSel)
      SYNC_WORD:  extValid = pinS2_q[`SSLC_PIN_WORD];
      SYNC_VIDEO: extValid = pinS2_q[`SSLC_PIN_VIDEO];
      default:    extValid = selDig[2] && pinS2_q[`SSLC_PIN_DIG_LSB + selDig[1:0]];
    endcase
  end

  // lock state ignores analog routing of the same pair
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      digLock          <= 1'b0;
      wordLock         <= 1'b0;
      videoLock        <= 1'b0;
      clockSrcInternal <= 1'b1;
      extValid_q       <= 1'b0;
      lockLost         <= 1'b0;
    end else if (ce) begin
      digLock          <= selDig[2] && extValid;
      wordLock         <= (syncSel == SYNC_WORD) && extValid;
      videoLock        <= (syncSel == SYNC_VIDEO) && extValid;
      clockSrcInternal <= !extValid;
      extValid_q       <= extValid;
      lockLost         <= extValid_q && !extValid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      inputRateConvEnable <= '1;
      activityFlash       <= '0;
    end else if (ce) begin
      inputRateConvEnable <= {`SSLC_NUM_PAIRS{syncSel == SYNC_INTERNAL}};
      for (int i = 0; i < `SSLC_NUM_PAIRS; i++) begin
        activityFlash[i] <= selDig[2] && (selDig[1:0] == 2'(i)) && !extValid
                            && blink_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      blinkCnt_q <= 32'h0;
      blink_q    <= 1'b0;
    end else if (ce) begin
      if (blinkCnt_q >= FLASH_CYCLES - 1) begin
        blinkCnt_q <= 32'h0;
        blink_q    <= !blink_q;
      end else begin
        blinkCnt_q <= blinkCnt_q + 32'h1;
      end
    end
  end

  // word clock for the link: internal generator or the locked reference
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      divCnt_q   <= '0;
      genTick_q  <= 1'b0;
      wordClkOut <= 1'b0;
    end else if (ce) begin
      if (divCnt_q + `SSLC_DIV_W'(1) >= intRateHalfDiv) begin
        divCnt_q  <= '0;
        genTick_q <= !genTick_q;
      end else begin
        divCnt_q <= divCnt_q + `SSLC_DIV_W'(1);
      end
      wordClkOut <= clockSrcInternal ? genTick_q : pinS2_q[`SSLC_PIN_REF];
    end
  end

  sslc_rate_meter #(
    .GATE_CYCLES (GATE_CYCLES),
    .RATE_W      (`SSLC_RATE_W)
  ) u_rate (
    .clk       (mclk),
    .rstN      (reset_n),
    .ce        (ce),
    .enable    (extValid && (syncSel != SYNC_VIDEO)),
    .edgePulse (pinS2_q[`SSLC_PIN_REF] && !refPrev_q),
    .rate      (measuredRate),
    .rateValid (rateValid)
  );

  // link domain: reset and enable brought over, received frames held
  logic                   lRst1_q, lRst2_q, lCe1_q, lCe2_q;
  logic                   rxTog_q;
  logic [1:0]             rxCmdH_q;
  logic [`SSLC_PRE_W-1:0] rxPreH_q;
  logic [`SSLC_TC_W-1:0]  rxTcH_q;
  logic                   reqS1_q, reqS2_q, reqS3_q, ackTog_q;

  always_ff @(posedge linkClk) begin
    lRst1_q <= reset_n;
    lRst2_q <= lRst1_q;
    lCe1_q  <= ce;
    lCe2_q  <= lCe1_q;
  end

  always_ff @(posedge linkClk) begin
    if (!lRst2_q) begin
      rxTog_q  <= 1'b0;
      rxCmdH_q <= CMD_NONE;
      rxPreH_q <= '0;
      rxTcH_q  <= '0;
    end else if (lCe2_q && linkInStrobe) begin
      rxTog_q  <= !rxTog_q;
      rxCmdH_q <= linkInCmd;
      rxPreH_q <= linkInPreroll;
      rxTcH_q  <= linkInTc;
    end
  end

  logic [`SSLC_PRE_W-1:0] txPre_q;
  logic [`SSLC_TC_W-1:0]  txTc_q;
  logic [1:0]             txCmd_q;
  logic                   txReq_q;

  always_ff @(posedge linkClk) begin
    if (!lRst2_q) begin
      reqS1_q        <= 1'b0;
      reqS2_q        <= 1'b0;
      reqS3_q        <= 1'b0;
      ackTog_q       <= 1'b0;
      linkOutStrobe  <= 1'b0;
      linkOutCmd     <= CMD_NONE;
      linkOutPreroll <= '0;
      linkOutTc      <= '0;
    end else if (lCe2_q) begin
      reqS1_q       <= txReq_q;
      reqS2_q       <= reqS1_q;
      reqS3_q       <= reqS2_q;
      linkOutStrobe <= reqS2_q != reqS3_q;
      if (reqS2_q != reqS3_q) begin
        linkOutCmd     <= txCmd_q;
        linkOutPreroll <= txPre_q;
        linkOutTc      <= txTc_q;
        ackTog_q       <= reqS2_q;
      end
    end
  end

  // mclk side of both crossings and the transport control
  logic       rxS1_q, rxS2_q, rxS3_q, ackS1_q, ackS2_q;
  logic       rxApply, txBusy, txLoad_q;
  sslc_role_e role_q;
  sslc_rec_e  rec_q;
  sslc_cmd_e  cmdEff, pend_q;

  assign txBusy  = txReq_q != ackS2_q;
  assign rxApply = (rxS2_q != rxS3_q) && (role_q == ROLE_SLAVE);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      {rxS1_q, rxS2_q, rxS3_q, ackS1_q, ackS2_q} <= 5'h00;
    end else if (ce) begin
      {rxS1_q, rxS2_q, rxS3_q} <= {rxTog_q, rxS1_q, rxS2_q};
      {ackS1_q, ackS2_q}       <= {ackTog_q, ackS1_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      role_q <= ROLE_NONE;
    end else if (ce) begin
      if (hostConnMode) begin
        role_q <= ROLE_NONE;
      end else if (role_q == ROLE_NONE) begin
        if (pinS2_q[`SSLC_PIN_LINK_IN]) begin
          role_q <= ROLE_SLAVE;
        end else if (pinS2_q[`SSLC_PIN_LINK_OUT]) begin
          role_q <= ROLE_MASTER;
        end
      end
    end
  end

  // a received command wins over a local press in the same cycle
  always_comb begin
    if (rxApply) begin
      cmdEff = sslc_cmd_e'(rxCmdH_q);
    end else if (stopPress) begin
      cmdEff = CMD_STOP;
    end else if (recPress && rec_q == REC_IDLE) begin
      cmdEff = CMD_REC;
    end else if (recPress && markerNewFile) begin
      cmdEff = CMD_SPLIT;
    end else if (fileLimit && rec_q == REC_RUN) begin
      cmdEff = CMD_SPLIT;
    end else begin
      cmdEff = CMD_NONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rec_q         <= REC_IDLE;
      newFilePulse  <= 1'b0;
      prerollActive <= `SSLC_PREROLL_RESET;
      rxTimeCode    <= '0;
    end else if (ce) begin
      newFilePulse <= (cmdEff == CMD_SPLIT) && (rec_q == REC_RUN);
      case (cmdEff)
        CMD_REC:  rec_q <= REC_RUN;
        CMD_STOP: rec_q <= REC_IDLE;
        default:  rec_q <= rec_q;
      endcase
      if (role_q != ROLE_SLAVE) begin
        prerollActive <= prerollLen;
      end else if (rxApply) begin
        prerollActive <= rxPreH_q;
        rxTimeCode    <= rxTcH_q;
      end
    end
  end

  // only the master's own commands and relayed ones go downstream
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pend_q   <= CMD_NONE;
      txReq_q  <= 1'b0;
      txLoad_q <= 1'b0;
      txCmd_q  <= CMD_NONE;
      txPre_q  <= '0;
      txTc_q   <= '0;
    end else if (ce) begin
      txLoad_q <= 1'b0;
      if ((role_q == ROLE_MASTER || rxApply) && cmdEff != CMD_NONE) begin
        pend_q <= cmdEff;
      end else if (pend_q != CMD_NONE && !txBusy && !hostConnMode) begin
        pend_q   <= CMD_NONE;
        txReq_q  <= !txReq_q;
        txLoad_q <= 1'b1;
        txCmd_q  <= pend_q;
        txPre_q  <= prerollActive;
        txTc_q   <= role_q == ROLE_SLAVE ? rxTimeCode : timeCodeIn;
      end
    end
  end

  assign recordActive = rec_q;
  assign linkRole     = role_q;

  a_src_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && syncSel != SYNC_INTERNAL) |=> inputRateConvEnable == 4'h0)
    else $error("rate converters active with external reference");
  a_dig_lock: assert property (@(posedge mclk) disable iff (!reset_n)
    digLock |-> ($past(selDig[2]) && $past(extValid)))
    else $error("digital lock without valid selected pair");
  a_flash_lock: assert property (@(posedge mclk) disable iff (!reset_n)
    digLock |-> activityFlash == 4'h0)
    else $error("ring flashes while locked");
  a_fallback_int: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && !extValid) |=> clockSrcInternal)
    else $error("no fallback to internal generator");
  a_lost_event: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && extValid ##1 ce && !extValid) |=> lockLost ##1 (!lockLost || !ce))
    else $error("lock-lost event wrong");
  a_host_off: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && hostConnMode) |=> (linkRole == ROLE_NONE) && !txLoad_q)
    else $error("link active in host connection mode");
  a_slave_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && role_q == ROLE_SLAVE && !rxApply && pend_q == CMD_NONE) |=> !txLoad_q)
    else $error("slave local command sent on link");
  a_master_rec: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && role_q == ROLE_MASTER && recPress && !stopPress && rec_q == REC_IDLE)
      |=> recordActive && pend_q == CMD_REC)
    else $error("master record not started or not queued");
endmodule

/* File: testbench/sslc_link_partner.sv */
// far-side link partner: upstream frame sender and downstream frame listener
// assumes linkClk runs free from the bench
module sslc_link_partner (
  input  wire logic        linkClk,
  input  wire logic        outStb,
  input  wire logic [1:0]  outCmd,
  input  wire logic [7:0]  outPre,
  input  wire logic [31:0] outTc,
  output logic             inStb,
  output logic [1:0]       inCmd,
  output logic [7:0]       inPre,
  output logic [31:0]      inTc
);
  timeunit 1ns;
  timeprecision 100ps;
  int          rxCnt = 0;
  logic [1:0]  rxCmd = 2'h0;
  logic [7:0]  rxPre = 8'h00;
  logic [31:0] rxTc  = 32'h0;
  initial begin
    inStb = 1'b0;
    inCmd = 2'h0;
    inPre = 8'h00;
    inTc  = 32'h0;
  end
  always @(posedge linkClk) begin
    if (outStb === 1'b1) begin
      rxCnt <= rxCnt + 1;
      rxCmd <= outCmd;
      rxPre <= outPre;
      rxTc  <= outTc;
    end
  end
  // one frame: strobe for one cycle, then words released to their inverse
  task automatic send(input logic [1:0] c, input logic [7:0] p, input logic [31:0] t);
    @(posedge linkClk);
    #1;
    inStb = 1'b1;
    inCmd = c;
    inPre = p;
    inTc  = t;
    @(posedge linkClk);
    #1;
    inStb = 1'b0;
    inCmd = ~c;
    inPre = ~p;
    inTc  = ~t;
  endtask
endmodule

/* File: testbench/sslc_top_tb.sv */
// self-checking bench for the sync source and link control block
// assumes the partner model stands at the link pins
module sslc_top_tb import sslc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FL = 8;
  localparam int GT = 64;
  logic        mclk = 1'b0, linkClk = 1'b0, reset_n = 1'b0, refClkIn = 1'b0;
  logic [2:0]  syncSel = 3'h0;
  logic        wordClkValid = 1'b0, videoValid = 1'b0, hostConnMode = 1'b0;
  logic        linkInConnected = 1'b0, linkOutConnected = 1'b0, markerNewFile = 1'b0;
  logic        recPress = 1'b0, stopPress = 1'b0, fileLimit = 1'b0;
  logic [3:0]  digValid = 4'h0;
  logic [7:0]  prerollLen = 8'h00;
  logic [31:0] timeCodeIn = 32'h0;
  logic        inStb, digLock, wordLock, videoLock, clkInt, lockLost, rateValid, wco;
  logic        recordActive, newFilePulse, outStb;
  logic [1:0]  inCmd, linkRole, outCmd;
  logic [3:0]  activityFlash, rateConv;
  logic [7:0]  inPre, prerollActive, outPre;
  logic [15:0] measuredRate;
  logic [31:0] inTc, rxTimeCode, outTc;
  int          checks = 0, num_errors = 0, nfCnt = 0, llCnt = 0, cycles = 0;
  logic [2:0]  dsel [4] = '{SYNC_DIG12, SYNC_DIG34, SYNC_DIG56, SYNC_DIG78};

  sslc_top #(.FLASH_CYCLES(FL), .GATE_CYCLES(GT)) uut (
    .mclk(mclk), .reset_n(reset_n), .ce(1'b1), .syncSel(syncSel),
    .wordClkValid(wordClkValid), .videoValid(videoValid), .digValid(digValid),
    .refClkIn(refClkIn), .intRateHalfDiv(12'h004), .hostConnMode(hostConnMode),
    .linkInConnected(linkInConnected), .linkOutConnected(linkOutConnected),
    .recPress(recPress), .stopPress(stopPress), .fileLimit(fileLimit),
    .markerNewFile(markerNewFile), .prerollLen(prerollLen), .timeCodeIn(timeCodeIn),
    .linkClk(linkClk), .linkInStrobe(inStb), .linkInCmd(inCmd), .linkInPreroll(inPre),
    .linkInTc(inTc), .digLock(digLock), .wordLock(wordLock), .videoLock(videoLock),
    .activityFlash(activityFlash), .inputRateConvEnable(rateConv),
    .clockSrcInternal(clkInt), .lockLost(lockLost), .measuredRate(measuredRate),
    .rateValid(rateValid), .wordClkOut(wco), .linkRole(linkRole),
    .recordActive(recordActive), .newFilePulse(newFilePulse),
    .prerollActive(prerollActive), .rxTimeCode(rxTimeCode), .linkOutStrobe(outStb),
    .linkOutCmd(outCmd), .linkOutPreroll(outPre), .linkOutTc(outTc)
  );
  sslc_link_partner lp (
    .linkClk(linkClk), .outStb(outStb), .outCmd(outCmd), .outPre(outPre),
    .outTc(outTc), .inStb(inStb), .inCmd(inCmd), .inPre(inPre), .inTc(inTc)
  );

  always #25 mclk = ~mclk;
  always #7.5 linkClk = ~linkClk;
  // reference clock of eight mclk cycles
  always #200 refClkIn = ~refClkIn;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (newFilePulse === 1'b1) nfCnt <= nfCnt + 1;
    if (lockLost === 1'b1) llCnt <= llCnt + 1;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk_bit(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic wait_out(input int n0, input logic [1:0] c);
    for (int k = 0; k < 60 && lp.rxCnt == n0; k++) cyc(1);
    chk_word(32'(n0 + 1), 32'(lp.rxCnt));
    chk_word(32'(c), 32'(lp.rxCmd));
  endtask
  task automatic split_by(ref logic s);
    int n0, n1;
    n0 = lp.rxCnt;
    n1 = nfCnt;
    pulse(s);
    wait_out(n0, CMD_SPLIT);
    chk_word(32'(n1 + 1), 32'(nfCnt));
    cyc(10);
  endtask
  task automatic complete_run;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    int n0, n1;
    logic [3:0] fOr;
    logic fZ;
    cyc(4);
    chk_word(32'hF, 32'(rateConv));
    chk_bit(1'b1, clkInt);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      syncSel = dsel[i];
      digValid = 4'h1 << i;
      cyc(5);
      chk_bit(1'b1, digLock);
      chk_bit(1'b0, clkInt);
      chk_word(32'h0, 32'(rateConv));
      n0 = llCnt;
      digValid = 4'h0;
      fOr = 4'h0;
      fZ = 1'b0;
      for (int k = 0; k < 4 * FL; k++) begin
        cyc(1);
        fOr = fOr | activityFlash;
        fZ = fZ | (activityFlash == 4'h0);
      end
      chk_word(32'(4'h1 << i), 32'(fOr));
      chk_bit(1'b1, fZ);
      chk_bit(1'b0, digLock);
      chk_bit(1'b1, clkInt);
      chk_word(32'(n0 + 1), 32'(llCnt));
    end
    syncSel = SYNC_WORD;
    wordClkValid = 1'b1;
    cyc(3 * GT);
    chk_bit(1'b1, wordLock);
    chk_bit(1'b1, rateValid);
    chk_bit(1'b1, measuredRate inside {16'h7, 16'h8, 16'h9});
    syncSel = SYNC_VIDEO;
    videoValid = 1'b1;
    cyc(5);
    chk_bit(1'b1, videoLock);
    syncSel = SYNC_INTERNAL;
    cyc(4);
    chk_word(32'hF, 32'(rateConv));
    chk_bit(1'b0, rateValid);
    fOr = 4'h0;
    fZ = 1'b0;
    for (int k = 0; k < 10; k++) begin
      cyc(1);
      fOr[0] = fOr[0] | wco;
      fZ = fZ | !wco;
    end
    chk_bit(1'b1, fOr[0] && fZ);
    prerollLen = 8'h5A;
    timeCodeIn = 32'h1234ABCD;
    linkOutConnected = 1'b1;
    cyc(5);
    chk_word(32'(ROLE_MASTER), 32'(linkRole));
    n0 = lp.rxCnt;
    pulse(recPress);
    chk_bit(1'b1, recordActive);
    wait_out(n0, CMD_REC);
    chk_word(32'h5A, 32'(lp.rxPre));
    chk_word(32'h1234ABCD, lp.rxTc);
    cyc(10);
    n1 = nfCnt;
    pulse(recPress);
    cyc(4);
    chk_word(32'(n1), 32'(nfCnt));
    split_by(fileLimit);
    markerNewFile = 1'b1;
    split_by(recPress);
    n0 = lp.rxCnt;
    pulse(stopPress);
    wait_out(n0, CMD_STOP);
    chk_bit(1'b0, recordActive);
    hostConnMode = 1'b1;
    cyc(3);
    chk_word(32'(ROLE_NONE), 32'(linkRole));
    hostConnMode = 1'b0;
    reset_n = 1'b0;
    linkOutConnected = 1'b0;
    cyc(4);
    reset_n = 1'b1;
    linkInConnected = 1'b1;
    syncSel = SYNC_WORD;
    cyc(5);
    chk_word(32'(ROLE_SLAVE), 32'(linkRole));
    n0 = lp.rxCnt;
    lp.send(CMD_REC, 8'h3C, 32'h00C0FFEE);
    cyc(8);
    chk_bit(1'b1, recordActive);
    chk_word(32'h3C, 32'(prerollActive));
    chk_word(32'h00C0FFEE, rxTimeCode);
    wait_out(n0, CMD_REC);
    cyc(10);
    n0 = lp.rxCnt;
    pulse(stopPress);
    cyc(30);
    chk_bit(1'b0, recordActive);
    chk_word(32'(n0), 32'(lp.rxCnt));
    lp.send(CMD_REC, 8'h3C, 32'h00C0FFEE);
    cyc(30);
    n1 = nfCnt;
    lp.send(CMD_SPLIT, 8'h3C, 32'h00C0FFEE);
    cyc(10);
    chk_word(32'(n1 + 1), 32'(nfCnt));
    hostConnMode = 1'b1;
    cyc(30);
    chk_word(32'(ROLE_NONE), 32'(linkRole));
    lp.send(CMD_STOP, 8'h3C, 32'h00C0FFEE);
    cyc(10);
    chk_bit(1'b1, recordActive);
    complete_run();
  end
endmodule
